// ---- design/clc_pkg.sv ----
package clc_pkg;
   // Command block layout
   localparam int BLK_WORDS = 16;
   localparam int W_ERR = 0;
   localparam int W_CODE = 1;
   localparam int W_LINK = 2;
   localparam int W_LOCAL = 3;
   localparam int W_COUNT = 4;
   localparam int W_REMOTE = 5;
   localparam int W_TMO = 6;
   localparam int W_ADDR_HI = 10;
   localparam int W_ADDR_LO = 11;
   localparam int W_PORT = 12;
   // Command codes
   localparam logic [15:0] CMD_CLOSE = 16'h0002;
   localparam logic [15:0] CMD_WRITE = 16'h0201;
   // Client link numbers
   localparam logic [15:0] LINK_FIRST = 16'd19221;
   localparam logic [15:0] LINK_LAST = 16'd19228;
   // Word transfer limits
   localparam logic [15:0] COUNT_MAX = 16'd256;
   localparam logic [16:0] LOCAL_TOP = 17'h0_8000;
   localparam logic [31:0] ADDR_MAX = 32'hDFFF_FFFF;
   // Reply timeout
   localparam logic [15:0] TMO_DEFAULT_S = 16'd9;
   localparam logic [15:0] TMO_INFINITE = 16'd999;
   localparam int SEC_NS = 1_000_000_000;
   localparam int CLK_NS = 10;
   localparam int SEC_CYCLES = SEC_NS / CLK_NS;
   // Error words
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] ERR_CMD = 16'h0001;
   localparam logic [15:0] ERR_LINK = 16'h0002;
   localparam logic [15:0] ERR_COUNT = 16'h0003;
   localparam logic [15:0] ERR_RANGE = 16'h0004;
   localparam logic [15:0] ERR_ADDR = 16'h0005;
   localparam logic [15:0] ERR_TIMEOUT = 16'h0006;
   localparam logic [15:0] ERR_REMOTE = 16'h0007;
   localparam logic [15:0] ERR_SRC_STREAM = 16'h0008;
   localparam logic [15:0] ERR_OPEN_BUSY = 16'h0009;
   localparam logic [15:0] ERR_NOT_CONN = 16'h240A;
   localparam logic [15:0] ERR_INACTIVE = 16'h00A6;
   // Host register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_LINK = 8'h04;
   localparam logic [7:0] REG_LOCAL = 8'h08;
   localparam logic [7:0] REG_COUNT = 8'h0C;
   localparam logic [7:0] REG_REMOTE = 8'h10;
   localparam logic [7:0] REG_TMO = 8'h14;
   localparam logic [7:0] REG_PADDR = 8'h18;
   localparam logic [7:0] REG_PPORT = 8'h1C;
   localparam logic [7:0] REG_STATUS = 8'h20;
   localparam logic [7:0] REG_ERRW = 8'h24;
   localparam logic [7:0] REG_MEM = 8'h40;
   // Control bits
   localparam int CTRL_GO = 0;
   localparam int CTRL_OP_WRITE = 1;
   localparam int CTRL_ACK = 2;
   localparam int MEM_WORDS = 16;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FETCH = 3'b001,
      ST_WAIT = 3'b010,
      ST_HOLD = 3'b011
   } clc_state_t;
endpackage : clc_pkg

// ---- design/clc_if.sv ----
`timescale 1ns/1ps
interface clc_if;
   logic cmd_valid;
   logic [15:0][15:0] blk;
   logic done;
   logic [15:0] err_word;
   logic err_ack;
   logic mem_req;
   logic [14:0] mem_addr;
   logic mem_ack;
   logic [15:0] mem_rdata;

   modport dev (input cmd_valid, input blk, output done, output err_word, input err_ack,
                output mem_req, output mem_addr, input mem_ack, input mem_rdata);
   modport host (output cmd_valid, output blk, input done, input err_word, output err_ack,
                 input mem_req, input mem_addr, output mem_ack, output mem_rdata);
endinterface : clc_if

// ---- design/clc_dev.sv ----
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module clc_dev #(
   parameter int SEC_CYCLES = clc_pkg::SEC_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   clc_if.dev bus,
   input wire logic open_valid,
   input wire logic [15:0] open_link,
   input wire logic open_stream,
   input wire logic open_src,
   input wire logic [31:0] open_addr,
   input wire logic [15:0] open_port,
   output logic open_done,
   output logic [15:0] open_err,
   input wire logic [7:0] link_drop,
   output logic tx_valid,
   output logic tx_first,
   output logic tx_last,
   output logic [15:0] tx_data,
   output logic [31:0] tx_addr,
   output logic [15:0] tx_port,
   output logic [15:0] tx_remote,
   output logic [15:0] tx_count,
   input wire logic tx_ready,
   input wire logic rx_valid,
   input wire logic rx_ok
);
   typedef struct packed {
      clc_pkg::clc_state_t st;
      logic [7:0] open;
      logic [7:0] stream;
      logic [7:0] src;
      logic [7:0] lost;
      logic [7:0] close_pend;
      logic [7:0][31:0] addr;
      logic [7:0][15:0] port;
      logic [14:0] laddr;
      logic [8:0] left;
      logic [31:0] div;
      logic [15:0] tsec;
      logic [15:0] tlim;
      logic inf;
      logic done;
      logic [15:0] err;
      logic mem_req;
      logic open_done;
      logic [15:0] open_err;
      logic tx_valid;
      logic tx_first;
      logic tx_last;
      logic [15:0] tx_data;
      logic [31:0] tx_addr;
      logic [15:0] tx_port;
      logic [15:0] tx_remote;
      logic [15:0] tx_count;
   } clc_dev_state_t;

   clc_dev_state_t s_q;
   clc_dev_state_t s_d;

   // Client link number check, used for open, release and transfer
   function automatic logic is_client(input logic [15:0] link);
      is_client = (link >= clc_pkg::LINK_FIRST) && (link <= clc_pkg::LINK_LAST);
   endfunction : is_client

   // Table index of a client link
   function automatic logic [2:0] link_idx(input logic [15:0] link);
      logic [15:0] off;
      off = link - clc_pkg::LINK_FIRST;
      link_idx = off[2:0];
   endfunction : link_idx

   // Peer address sanity
   function automatic logic addr_bad(input logic [31:0] a);
      addr_bad = (a == 32'h0000_0000) || (a > clc_pkg::ADDR_MAX);
   endfunction : addr_bad

   logic [15:0] code;
   logic [15:0] link;
   logic [2:0] idx;
   logic [15:0] cnt;
   logic [15:0] lstart;
   logic [15:0] rstart;
   logic [31:0] blk_addr;
   logic [16:0] lend;
   logic [2:0] oidx;

   // Fields of the block held by the issuer
   assign code = bus.blk[clc_pkg::W_CODE];
   assign link = bus.blk[clc_pkg::W_LINK];
   assign idx = link_idx(link);
   assign cnt = bus.blk[clc_pkg::W_COUNT];
   assign lstart = bus.blk[clc_pkg::W_LOCAL];
   assign rstart = bus.blk[clc_pkg::W_REMOTE];
   assign blk_addr = {bus.blk[clc_pkg::W_ADDR_HI], bus.blk[clc_pkg::W_ADDR_LO]};
   assign lend = {1'b0, lstart} + {1'b0, cnt} - 17'h0_0001;
   assign oidx = link_idx(open_link);

   // Next state
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.open_done = 1'b0;
      // Stream links that lose their peer are marked
      for (int i = 0; i < 8; i++) begin
         if (link_drop[i] && s_q.open[i] && s_q.stream[i]) begin
            s_d.lost[i] = 1'b1;
         end
      end
      // Acknowledged not-connected error closes the link
      if (bus.err_ack) begin
         for (int i = 0; i < 8; i++) begin
            if (s_q.close_pend[i]) begin
               s_d.open[i] = 1'b0;
               s_d.lost[i] = 1'b0;
               s_d.close_pend[i] = 1'b0;
            end
         end
      end
      // Link open requests from the network side
      if (open_valid) begin
         s_d.open_done = 1'b1;
         s_d.open_err = clc_pkg::ERR_NONE;
         if (!is_client(open_link)) begin
            s_d.open_err = clc_pkg::ERR_LINK;
         end else if (s_q.open[oidx]) begin
            s_d.open_err = clc_pkg::ERR_OPEN_BUSY;
         end else if (open_stream && open_src) begin
            s_d.open_err = clc_pkg::ERR_SRC_STREAM;
         end else if (addr_bad(open_addr)) begin
            s_d.open_err = clc_pkg::ERR_ADDR;
         end else begin
            s_d.open[oidx] = 1'b1;
            s_d.stream[oidx] = open_stream;
            s_d.src[oidx] = open_src;
            s_d.lost[oidx] = 1'b0;
            s_d.addr[oidx] = open_addr;
            s_d.port[oidx] = open_port;
         end
      end
      case (s_q.st)
         clc_pkg::ST_IDLE: begin
            if (bus.cmd_valid) begin
               s_d.st = clc_pkg::ST_HOLD;
               s_d.done = 1'b1;
               s_d.err = clc_pkg::ERR_NONE;
               if (code == clc_pkg::CMD_CLOSE) begin
                  if (!is_client(link)) begin
                     s_d.err = clc_pkg::ERR_LINK;
                  end else if (!s_q.open[idx]) begin
                     s_d.err = clc_pkg::ERR_INACTIVE;
                  end else begin
                     s_d.open[idx] = 1'b0;
                     s_d.lost[idx] = 1'b0;
                     s_d.close_pend[idx] = 1'b0;
                  end
               end else if (code == clc_pkg::CMD_WRITE) begin
                  if (!is_client(link)) begin
                     s_d.err = clc_pkg::ERR_LINK;
                  end else if (!s_q.open[idx] || s_q.close_pend[idx]) begin
                     s_d.err = clc_pkg::ERR_INACTIVE;
                  end else if (s_q.lost[idx]) begin
                     s_d.err = clc_pkg::ERR_NOT_CONN;
                     s_d.close_pend[idx] = 1'b1;
                  end else if (cnt == 16'h0000 || cnt > clc_pkg::COUNT_MAX) begin
                     s_d.err = clc_pkg::ERR_COUNT;
                  end else if (lstart == 16'h0000 || rstart == 16'h0000 || lend > clc_pkg::LOCAL_TOP) begin
                     s_d.err = clc_pkg::ERR_RANGE;
                  end else if (s_q.src[idx] && addr_bad(blk_addr)) begin
                     s_d.err = clc_pkg::ERR_ADDR;
                  end else begin
                     s_d.st = clc_pkg::ST_FETCH;
                     s_d.done = 1'b0;
                     s_d.err = s_q.err; // Last result stands until the next done
                     s_d.laddr = 15'(lstart - 16'h0001);
                     s_d.left = cnt[8:0];
                     s_d.tx_count = cnt;
                     s_d.tx_remote = rstart;
                     if (s_q.src[idx]) begin
                        s_d.tx_addr = blk_addr;
                        s_d.tx_port = bus.blk[clc_pkg::W_PORT];
                     end else begin
                        s_d.tx_addr = s_q.addr[idx];
                        s_d.tx_port = s_q.port[idx];
                     end
                     s_d.inf = (bus.blk[clc_pkg::W_TMO] == clc_pkg::TMO_INFINITE);
                     s_d.tlim = (bus.blk[clc_pkg::W_TMO] == 16'h0000) ? clc_pkg::TMO_DEFAULT_S
                                                                  : bus.blk[clc_pkg::W_TMO];
                  end
               end else begin
                  s_d.err = clc_pkg::ERR_CMD;
               end
            end
         end
         clc_pkg::ST_FETCH: begin
            // One local word at a time, streamed as one message
            if (!s_q.mem_req && !s_q.tx_valid) begin
               s_d.mem_req = 1'b1;
            end
            if (s_q.mem_req && bus.mem_ack) begin
               s_d.mem_req = 1'b0;
               s_d.tx_valid = 1'b1;
               s_d.tx_data = bus.mem_rdata;
               s_d.tx_first = ({7'h00, s_q.left} == s_q.tx_count);
               s_d.tx_last = (s_q.left == 9'h001);
            end
            if (s_q.tx_valid && tx_ready) begin
               s_d.tx_valid = 1'b0;
               s_d.laddr = s_q.laddr + 15'h0001;
               s_d.left = s_q.left - 9'h001;
               if (s_q.left == 9'h001) begin
                  s_d.st = clc_pkg::ST_WAIT;
                  s_d.div = 32'h0000_0000;
                  s_d.tsec = 16'h0000;
               end
            end
         end
         clc_pkg::ST_WAIT: begin
            if (rx_valid) begin
               s_d.st = clc_pkg::ST_HOLD;
               s_d.done = 1'b1;
               s_d.err = rx_ok ? clc_pkg::ERR_NONE : clc_pkg::ERR_REMOTE;
            end else if (!s_q.inf) begin
               s_d.div = s_q.div + 32'h0000_0001;
               if (s_q.div == 32'(SEC_CYCLES - 1)) begin
                  s_d.div = 32'h0000_0000;
                  s_d.tsec = s_q.tsec + 16'h0001;
                  if (s_q.tsec + 16'h0001 >= s_q.tlim) begin
                     s_d.st = clc_pkg::ST_HOLD;
                     s_d.done = 1'b1;
                     s_d.err = clc_pkg::ERR_TIMEOUT;
                  end
               end
            end
         end
         clc_pkg::ST_HOLD: begin
            // Wait for the issuer to withdraw the block
            if (!bus.cmd_valid) begin
               s_d.st = clc_pkg::ST_IDLE;
            end
         end
         default: begin
            s_d.st = clc_pkg::ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // Outputs straight from state
   assign bus.done = s_q.done;
   assign bus.err_word = s_q.err;
   assign bus.mem_req = s_q.mem_req;
   assign bus.mem_addr = s_q.laddr;
   assign open_done = s_q.open_done;
   assign open_err = s_q.open_err;
   assign tx_valid = s_q.tx_valid;
   assign tx_first = s_q.tx_first;
   assign tx_last = s_q.tx_last;
   assign tx_data = s_q.tx_data;
   assign tx_addr = s_q.tx_addr;
   assign tx_port = s_q.tx_port;
   assign tx_remote = s_q.tx_remote;
   assign tx_count = s_q.tx_count;
endmodule : clc_dev

// ---- design/clc_host.sv ----
`timescale 1ns/1ps
module clc_host #(
   parameter int MEM_WORDS = clc_pkg::MEM_WORDS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   clc_if.host bus,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   typedef struct packed {
      logic busy;
      logic op_write;
      logic done;
      logic err_flag;
      logic [15:0] err_word;
      logic [15:0] link;
      logic [15:0] local_start;
      logic [15:0] count;
      logic [15:0] remote_start;
      logic [15:0] tmo;
      logic [31:0] peer_addr;
      logic [15:0] peer_port;
      logic [MEM_WORDS-1:0][15:0] mem;
      logic err_ack;
      logic mem_ack;
      logic [15:0] mem_rdata;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } clc_host_state_t;

   clc_host_state_t s_q;
   clc_host_state_t s_d;
   logic [7:0] mem_off;
   logic mem_hit;
   logic [7:0] mem_i;
   logic reg_hit;

   // Decode of the word window and the register block
   assign mem_off = paddr - clc_pkg::REG_MEM;
   assign mem_hit = (paddr >= clc_pkg::REG_MEM) && (mem_off[7:2] < 6'(MEM_WORDS)) && (mem_off[1:0] == 2'b00);
   assign mem_i = {2'b00, mem_off[7:2]};
   assign reg_hit = (paddr <= clc_pkg::REG_ERRW) && (paddr[1:0] == 2'b00);

   // Next state
   always_comb begin
      s_d = s_q;
      s_d.err_ack = 1'b0;
      s_d.mem_ack = 1'b0;
      s_d.pready = 1'b0;
      // APB: one wait state, then answer
      if (psel && penable && !s_q.pready) begin
         s_d.pready = 1'b1;
         s_d.pslverr = !(reg_hit || mem_hit);
         s_d.prdata = 32'h0000_0000;
         case (paddr)
            clc_pkg::REG_LINK: s_d.prdata = {16'h0000, s_q.link};
            clc_pkg::REG_LOCAL: s_d.prdata = {16'h0000, s_q.local_start};
            clc_pkg::REG_COUNT: s_d.prdata = {16'h0000, s_q.count};
            clc_pkg::REG_REMOTE: s_d.prdata = {16'h0000, s_q.remote_start};
            clc_pkg::REG_TMO: s_d.prdata = {16'h0000, s_q.tmo};
            clc_pkg::REG_PADDR: s_d.prdata = s_q.peer_addr;
            clc_pkg::REG_PPORT: s_d.prdata = {16'h0000, s_q.peer_port};
            clc_pkg::REG_STATUS: s_d.prdata = {29'h0000_0000, s_q.err_flag, s_q.done, s_q.busy};
            clc_pkg::REG_ERRW: s_d.prdata = {16'h0000, s_q.err_word};
            default: begin
               if (mem_hit) begin
                  s_d.prdata = {16'h0000, s_q.mem[mem_i]};
               end
            end
         endcase
      end
      // Writes take effect on the completing edge
      if (psel && penable && s_q.pready && pwrite) begin
         case (paddr)
            clc_pkg::REG_CTRL: begin
               if (pwdata[clc_pkg::CTRL_ACK]) begin
                  s_d.err_flag = 1'b0;
                  s_d.err_ack = 1'b1;
               end
               if (pwdata[clc_pkg::CTRL_GO] && !s_q.busy) begin
                  s_d.busy = 1'b1;
                  s_d.done = 1'b0;
                  s_d.op_write = pwdata[clc_pkg::CTRL_OP_WRITE];
               end
            end
            clc_pkg::REG_LINK: s_d.link = pwdata[15:0];
            clc_pkg::REG_LOCAL: s_d.local_start = pwdata[15:0];
            clc_pkg::REG_COUNT: s_d.count = pwdata[15:0];
            clc_pkg::REG_REMOTE: s_d.remote_start = pwdata[15:0];
            clc_pkg::REG_TMO: s_d.tmo = pwdata[15:0];
            clc_pkg::REG_PADDR: s_d.peer_addr = pwdata;
            clc_pkg::REG_PPORT: s_d.peer_port = pwdata[15:0];
            default: begin
               if (mem_hit) begin
                  s_d.mem[mem_i] = pwdata[15:0];
               end
            end
         endcase
      end
      // Completion from the device; error bit set wins over ack
      if (s_q.busy && bus.done) begin
         s_d.busy = 1'b0;
         s_d.done = 1'b1;
         s_d.err_word = bus.err_word;
         if (bus.err_word != clc_pkg::ERR_NONE) begin
            s_d.err_flag = 1'b1;
         end
      end
      // Local word fetch, out-of-window words read zero
      if (bus.mem_req && !s_q.mem_ack) begin
         s_d.mem_ack = 1'b1;
         s_d.mem_rdata = (bus.mem_addr < 15'(MEM_WORDS)) ? s_q.mem[bus.mem_addr[3:0]] : 16'h0000;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // Command block: word 0 and unused words held at zero
   always_comb begin
      bus.blk = '0;
      bus.blk[clc_pkg::W_CODE] = s_q.op_write ? clc_pkg::CMD_WRITE : clc_pkg::CMD_CLOSE;
      bus.blk[clc_pkg::W_LINK] = s_q.link;
      if (s_q.op_write) begin
         bus.blk[clc_pkg::W_LOCAL] = s_q.local_start;
         bus.blk[clc_pkg::W_COUNT] = s_q.count;
         bus.blk[clc_pkg::W_REMOTE] = s_q.remote_start;
         bus.blk[clc_pkg::W_TMO] = s_q.tmo;
         bus.blk[clc_pkg::W_ADDR_HI] = s_q.peer_addr[31:16];
         bus.blk[clc_pkg::W_ADDR_LO] = s_q.peer_addr[15:0];
         bus.blk[clc_pkg::W_PORT] = s_q.peer_port;
      end
   end

   assign bus.cmd_valid = s_q.busy;
   assign bus.err_ack = s_q.err_ack;
   assign bus.mem_ack = s_q.mem_ack;
   assign bus.mem_rdata = s_q.mem_rdata;
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
endmodule : clc_host

// ---- verification/clc_chk.sv ----
`timescale 1ns/1ps
// Watches the command link between host and device ends
module clc_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cmd_valid,
   input wire logic [15:0][15:0] blk,
   input wire logic done,
   input wire logic [15:0] err_word,
   input wire logic err_ack,
   input wire logic mem_req,
   input wire logic [14:0] mem_addr,
   input wire logic mem_ack
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completion and result word
   a_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
   a_err_with_done: assert property ($changed(err_word) |-> done) else $error("error word moved without done");
   a_close_quick: assert property ($rose(cmd_valid) && blk[1] == clc_pkg::CMD_CLOSE |-> ##[1:3] done)
      else $error("release not answered");
   a_bad_link: assert property ($rose(cmd_valid) && (blk[2] < clc_pkg::LINK_FIRST || blk[2] > clc_pkg::LINK_LAST)
      |-> ##[1:3] (done && err_word != clc_pkg::ERR_NONE)) else $error("foreign link not refused");
   a_bad_count: assert property ($rose(cmd_valid) && blk[1] == clc_pkg::CMD_WRITE
      && (blk[4] == 16'h0000 || blk[4] > clc_pkg::COUNT_MAX) |-> ##[1:3] (done && err_word != clc_pkg::ERR_NONE))
      else $error("bad count not refused");
   // Local fetch stays inside the requested one-relative run
   a_fetch_range: assert property (mem_req |-> {2'b00, mem_addr} + 17'h0_0001 >= {1'b0, blk[3]}
      && {2'b00, mem_addr} + 17'h0_0001 < {1'b0, blk[3]} + {1'b0, blk[4]}) else $error("fetch outside run");
   a_ack_next: assert property ($rose(mem_req) |=> mem_ack) else $error("memory ack late");
   a_req_drop: assert property (mem_ack |=> !mem_req) else $error("fetch held after ack");
   // Block contents from the issuing side
   a_word0_clear: assert property (cmd_valid |-> blk[0] == 16'h0000) else $error("word 0 not cleared");
   a_close_zero: assert property (cmd_valid && blk[1] == clc_pkg::CMD_CLOSE |-> blk[15:3] == '0)
      else $error("release block not zero");
   a_write_zero: assert property (cmd_valid && blk[1] == clc_pkg::CMD_WRITE |-> blk[9:7] == '0 && blk[15:13] == '0)
      else $error("write block spare words set");
   c_fetch: cover property ($rose(mem_req));
   c_ok: cover property (done && err_word == clc_pkg::ERR_NONE);
   c_ack: cover property (err_ack);
endmodule : clc_chk

// ---- verification/tb_client_link_close_and_remote_write.sv ----
`timescale 1ns/1ps
module tb_client_link_close_and_remote_write;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
   logic [7:0] paddr, link_drop;
   logic [31:0] pwdata, prdata, open_addr, tx_addr, ga;
   logic open_valid, open_stream, open_src, open_done, tx_valid, tx_first, tx_last, tx_ready, rx_valid, rx_ok, peer_on;
   logic [15:0] open_link, open_port, open_err, tx_data, tx_port, tx_remote, tx_count, gp, gr, gc;
   logic [15:0] got[$];
   int fails, cmp_count;
   clc_if bif();
   clc_dev #(.SEC_CYCLES(10)) i_clc_dev (.pclk(pclk), .presetn(presetn), .ce(1'b1), .bus(bif.dev),
      .open_valid(open_valid), .open_link(open_link), .open_stream(open_stream), .open_src(open_src),
      .open_addr(open_addr), .open_port(open_port), .open_done(open_done), .open_err(open_err), .link_drop(link_drop),
      .tx_valid(tx_valid), .tx_first(tx_first), .tx_last(tx_last), .tx_data(tx_data), .tx_addr(tx_addr),
      .tx_port(tx_port), .tx_remote(tx_remote), .tx_count(tx_count), .tx_ready(tx_ready), .rx_valid(rx_valid),
      .rx_ok(rx_ok));
   clc_host i_clc_host (.pclk(pclk), .presetn(presetn), .ce(1'b1), .bus(bif.host), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   clc_chk i_clc_chk (.pclk(pclk), .presetn(presetn), .cmd_valid(bif.cmd_valid), .blk(bif.blk), .done(bif.done),
      .err_word(bif.err_word), .err_ack(bif.err_ack), .mem_req(bif.mem_req), .mem_addr(bif.mem_addr),
      .mem_ack(bif.mem_ack));
   // Clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Peer: stalls every other cycle, records the message, replies after the last word
   always @(posedge pclk) begin
      tx_ready <= ~tx_ready;
      rx_valid <= tx_valid && tx_ready && tx_last && peer_on; // Reply one edge after the last word
      if (tx_valid && tx_ready) begin
         got.push_back(tx_data);
         if (tx_first) begin
            ga <= tx_addr;
            gp <= tx_port;
            gr <= tx_remote;
            gc <= tx_count;
         end
      end
   end
   task give_verdict();
      $display("Compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : give_verdict
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // One APB transfer, held until pready, then one idle cycle
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      r = prdata;
      slverr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 20) begin fails++; give_verdict(); end
      @(posedge pclk);
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask : wr
   task opn(input logic [15:0] lk, input logic st, input logic sr, input logic [31:0] ad, input logic [15:0] e);
      open_link <= lk; open_stream <= st; open_src <= sr; open_addr <= ad; open_port <= 16'h05E1; open_valid <= 1'b1;
      @(posedge pclk);
      open_valid <= 1'b0;
      @(posedge pclk);
      chk(open_err, e);
   endtask : opn
   // Load a block, trigger it, wait for idle with done, compare the error word
   task cmd(input logic [31:0] go, input logic [15:0] lk, lo, cn, rm, tm, e);
      logic [31:0] r;
      int n;
      wr(clc_pkg::REG_LINK, {16'h0000, lk}); wr(clc_pkg::REG_LOCAL, {16'h0000, lo});
      wr(clc_pkg::REG_COUNT, {16'h0000, cn}); wr(clc_pkg::REG_REMOTE, {16'h0000, rm});
      wr(clc_pkg::REG_TMO, {16'h0000, tm});
      got.delete();
      wr(clc_pkg::REG_CTRL, go);
      n = 0;
      do begin apb(1'b0, clc_pkg::REG_STATUS, 32'h0000_0000, r); n++; end while ((r[0] !== 1'b0 || r[1] !== 1'b1) && n < 1000);
      if (n >= 1000) begin fails++; give_verdict(); end
      apb(1'b0, clc_pkg::REG_ERRW, 32'h0000_0000, r);
      chk(r, {16'h0000, e});
   endtask : cmd
   task s_write_ok();
      logic [31:0] r;
      opn(16'h4B15, 1'b0, 1'b0, 32'h0A00_0001, 16'h0000);
      cmd(32'h0000_0003, 16'h4B15, 16'h0002, 16'h0003, 16'h0005, 16'h0000, 16'h0000);
      for (int k = 0; k < 3; k++) chk(got[k], 32'h0000_1001 + k);
      chk(ga, 32'h0A00_0001); chk(gp, 16'h05E1); chk(gr, 16'h0005); chk(gc, 16'h0003);
      apb(1'b0, 8'h3C, 32'h0000_0000, r);
      chk({r[30:0], slverr}, 32'h0000_0001);
   endtask : s_write_ok
   task s_peer_fail();
      logic [31:0] r;
      rx_ok <= 1'b0;
      cmd(32'h0000_0003, 16'h4B15, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0007);
      apb(1'b0, clc_pkg::REG_STATUS, 32'h0000_0000, r);
      chk(r[2], 1'b1);
      wr(clc_pkg::REG_CTRL, 32'h0000_0004);
      apb(1'b0, clc_pkg::REG_STATUS, 32'h0000_0000, r);
      chk(r[2], 1'b0);
      rx_ok <= 1'b1;
   endtask : s_peer_fail
   // Count and local range boundaries: start, count, error, words sent
   task s_limits();
      logic [15:0] t[6][4] = '{'{16'h0001, 16'h0000, 16'h0003, 16'h0000}, '{16'h0001, 16'h0101, 16'h0003, 16'h0000},
         '{16'h0000, 16'h0001, 16'h0004, 16'h0000}, '{16'h8000, 16'h0002, 16'h0004, 16'h0000},
         '{16'h7FFF, 16'h0002, 16'h0000, 16'h0002}, '{16'h0001, 16'h0100, 16'h0000, 16'h0100}};
      for (int i = 0; i < 6; i++) begin
         cmd(32'h0000_0003, 16'h4B15, t[i][0], t[i][1], 16'h0001, 16'h0000, t[i][2]);
         chk(got.size(), t[i][3]);
      end
   endtask : s_limits
   task s_timeout();
      peer_on <= 1'b0;
      cmd(32'h0000_0003, 16'h4B15, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0006);
      peer_on <= 1'b1;
   endtask : s_timeout
   task s_peer_addr();
      opn(16'h4B16, 1'b0, 1'b1, 32'h0A00_0002, 16'h0000);
      wr(clc_pkg::REG_PPORT, 32'h0000_0007);
      wr(clc_pkg::REG_PADDR, 32'h0000_0000);
      cmd(32'h0000_0003, 16'h4B16, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0005);
      wr(clc_pkg::REG_PADDR, 32'hE000_0000);
      cmd(32'h0000_0003, 16'h4B16, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0005);
      wr(clc_pkg::REG_PADDR, 32'hDFFF_FFFF);
      cmd(32'h0000_0003, 16'h4B16, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0000);
      chk(ga, 32'hDFFF_FFFF); chk(gp, 16'h0007);
   endtask : s_peer_addr
   task s_stream();
      opn(16'h4B17, 1'b1, 1'b1, 32'h0A00_0003, 16'h0008);
      opn(16'h4B17, 1'b1, 1'b0, 32'h0A00_0003, 16'h0000);
      link_drop <= 8'h04;
      cmd(32'h0000_0003, 16'h4B17, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h240A);
      link_drop <= 8'h00;
      wr(clc_pkg::REG_CTRL, 32'h0000_0004);
      cmd(32'h0000_0003, 16'h4B17, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h00A6);
   endtask : s_stream
   task s_close();
      cmd(32'h0000_0001, 16'h4B15, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      cmd(32'h0000_0001, 16'h4B15, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00A6);
      opn(16'h4B15, 1'b0, 1'b0, 32'h0A00_0001, 16'h0000);
      cmd(32'h0000_0001, 16'h4A38, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0002);
   endtask : s_close
   // Reset, memory fill, scenarios
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
      open_valid = 1'b0; open_link = 16'h0000; open_stream = 1'b0; open_src = 1'b0; open_addr = 32'h0000_0000;
      open_port = 16'h0000; link_drop = 8'h00; tx_ready = 1'b0; rx_valid = 1'b0; rx_ok = 1'b1; peer_on = 1'b1;
      fails = 0; cmp_count = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 16; i++) wr(clc_pkg::REG_MEM + 8'(4 * i), 32'h0000_1000 + i);
      s_write_ok(); s_peer_fail(); s_limits(); s_timeout(); s_peer_addr(); s_stream(); s_close();
      give_verdict();
   end
endmodule : tb_client_link_close_and_remote_write
